// ==== include/pdt_pkg.sv ====
// Purpose: Shared constants and types for the prescaled downcounter timer.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Printed offsets are register indices; byte address is four times the index.
package pdt_pkg;
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_PSC = 8'hd2;
    localparam logic [7:0] IDX_CNT = 8'hd3;
    localparam logic [7:0] IDX_CTL = 8'hd4;
    localparam logic [ADDR_W-1:0] ADDR_PSC = {2'h0, IDX_PSC, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CNT = {2'h0, IDX_CNT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTL = {2'h0, IDX_CTL, 2'h0};
    localparam int CNT_W = 8;
    localparam int PSC_W = 7;
    localparam int SEL_W = 3;
    localparam logic [CNT_W-1:0] CNT_RELOAD = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [PSC_W-1:0] PSC_RELOAD = 7'h7f;
    localparam logic [PSC_W-1:0] PSC_ZERO = 7'h00;
    localparam int INT_DIV = 12;
    localparam int CLK_MHZ = 100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTL_ZF_BIT = 7;

    typedef enum logic [1:0] {
        PDT_EVENT,
        PDT_GATED,
        PDT_OUTPUT
    } pdt_mode_e;

    // Status/control register layout, most significant bit first.
    typedef struct packed {
        logic zero_flag;
        logic zero_irq_enable;
        logic pin_direction_select;
        logic data_bit;
        logic prescale_run;
        logic [SEL_W-1:0] prescale_select;
    } pdt_ctl_s;

    localparam pdt_ctl_s CTL_RESET = 8'h00;

    // Pin drive group.
    typedef struct packed {
        logic level;
        logic enable;
    } pdt_pin_s;
endpackage : pdt_pkg

// ==== core/pdt_timer.sv ====
// Purpose: 8-bit downcounter timer with a 7-bit prescaler and pin modes.
// Assumes: AXI4-Lite slave, one write and one read outstanding at most.
// Notes: The external pin is synchronised; all logic runs on clock_i.
//
// Overview of operation
// R1 - Counter is always an 8-bit downcounter; select only sets its clock rate.
// R2 - Counting down to zero sets the zero flag.
// R3 - Interrupt request is zero flag AND zero interrupt enable.
// R4 - The interrupt request doubles as the wake request from idle and halt.
// R5 - Software may write the count register at any time to load a count.
// R6 - Writing 00h to count, or one to control bit 7, sets the zero flag.
// R7 - Software clears the zero flag before leaving its interrupt handler.
// R8 - A count write beats a simultaneous decrement to zero; no flag then.
// R9 - Direction and data bits pick event, gated or output mode.
// R10 - The 7-bit prescaler takes internal clock over 12 or the pin.
// R11 - Gated mode counts divided ticks only while the pin is high.
// R12 - Software sets a shared port bit as input with pull-up for inputs.
// R13 - Event mode decrements the prescaler on each rising pin edge.
// R14 - Output mode clocks the prescaler from internal clock over 12.
// R15 - Rising zero flag latches the data bit; output mode drives it out.
// R16 - Direction set makes the pin a push-pull output at once.
// R17 - Counter reloads FFh after zero and resets to FFh.
// R18 - Prescaler reloads 7Fh after zero and resets to 7Fh.
// R19 - Run bit clear freezes counter and holds prescaler at 7Fh.
// R20 - Select field picks one of 8 taps: divide by two to the field.
// R21 - The pin is synchronised and edge-detected before use.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module pdt_timer
    import pdt_pkg::*;
#(
    parameter int DIV = INT_DIV
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic srst_i,
    // AXI4-Lite write channels.
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels.
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Timer pin.
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    // Interrupt and wake request.
    output logic irq_o
);

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_PSC) || (a == ADDR_CNT) || (a == ADDR_CTL);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    pdt_ctl_s ctl;
    logic [CNT_W-1:0] count_register;
    logic [PSC_W-1:0] prescaler;
    logic out_latch;
    logic [3:0] div_cnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode. Address and data are taken together, so a lone channel waits.
    wire wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid;
    wire wr_lane = s_axi_wstrb_i[0];
    wire wr_psc = wr_go && wr_lane && (s_axi_awaddr_i == ADDR_PSC);
    wire wr_cnt = wr_go && wr_lane && (s_axi_awaddr_i == ADDR_CNT);
    wire wr_ctl = wr_go && wr_lane && (s_axi_awaddr_i == ADDR_CTL);
    wire [7:0] wbyte = s_axi_wdata_i[7:0];
    wire rd_go = s_axi_arvalid_i && !rvalid;
    wire [7:0] rd_byte = (s_axi_araddr_i == ADDR_PSC) ? {1'b0, prescaler} :
                         (s_axi_araddr_i == ADDR_CNT) ? count_register :
                         (s_axi_araddr_i == ADDR_CTL) ? ctl : 8'h00;

    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_arready_o = rd_go;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;

    ////////////////////////////////////////////////////////////////////////
    // Mode and clock selection.
    wire [1:0] mode_bits = {ctl.pin_direction_select, ctl.data_bit};
    wire pdt_mode_e mode = mode_bits[1] ? PDT_OUTPUT :               // R9
                           mode_bits[0] ? PDT_GATED : PDT_EVENT;     // R9
    wire div_tick = (div_cnt == 4'(DIV - 1));                         // R10
    wire pin_rise = pin_s2 && !pin_s3;                               // R21
    wire psc_tick = (mode == PDT_EVENT) ? pin_rise :                 // R13
                    (mode == PDT_GATED) ? (div_tick && pin_s2) :     // R11
                    div_tick;                                        // R14
    wire psc_step = ctl.prescale_run && psc_tick;                    // R19
    // Tap n fires once per 2^n prescaler steps, when its low n bits are all zero.
    wire [PSC_W-1:0] tap_mask = PSC_W'((8'h01 << ctl.prescale_select) - 8'h01);
    wire cnt_tick = psc_step && ((prescaler & tap_mask) == PSC_ZERO); // R20
    wire cnt_hits_zero = cnt_tick && (count_register == 8'h01);       // R2
    wire zf_set = (cnt_hits_zero && !wr_cnt) ||                       // R8
                  (wr_cnt && wbyte == CNT_ZERO) ||                    // R6
                  (wr_ctl && wbyte[CTL_ZF_BIT]);                      // R6
    // Software clears only with a zero in bit 7; a hardware set wins that cycle.
    wire zf_clr = wr_ctl && !wbyte[CTL_ZF_BIT];
    wire next_zf = zf_set ? 1'b1 : (zf_clr ? 1'b0 : ctl.zero_flag);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and divide-by-12 tick.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            // Reset to the pulled-up idle level, so no false edge follows reset.
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            div_cnt <= 4'h0;
        end else begin
            pin_s1 <= pin_i;                                         // R21
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            div_cnt <= div_tick ? 4'h0 : div_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: held at reload while stopped, writable while running.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            prescaler <= PSC_RELOAD;                                 // R18
        end else if (!ctl.prescale_run) begin
            prescaler <= PSC_RELOAD;                                 // R19
        end else if (wr_psc) begin
            prescaler <= wbyte[PSC_W-1:0];
        end else if (psc_step) begin
            prescaler <= (prescaler == PSC_ZERO) ? PSC_RELOAD : prescaler - 7'h01; // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: a write always takes precedence over a decrement.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            count_register <= CNT_RELOAD;                            // R17
        end else if (wr_cnt) begin
            count_register <= wbyte;                                 // R5
        end else if (cnt_tick) begin
            count_register <= count_register - 8'h01;                // R1 R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, flag and output latch.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctl <= CTL_RESET;
            out_latch <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl[6:0] <= wbyte[6:0];
            end
            ctl.zero_flag <= next_zf;                                // R2
            if (next_zf && !ctl.zero_flag) begin
                out_latch <= ctl.data_bit;                           // R15
            end
        end
    end

    assign pin_o = out_latch;                                        // R15
    assign pin_oe_o = ctl.pin_direction_select;                      // R16
    assign irq_o = ctl.zero_flag && ctl.zero_irq_enable;             // R3 R4

    ////////////////////////////////////////////////////////////////////////
    // Bus responses.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= is_mapped(s_axi_awaddr_i) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid <= 1'b0;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata <= {24'h0, rd_byte};
                rresp <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    a_zero_sets_flag: assert property (cnt_hits_zero && !wr_cnt |=> ctl.zero_flag) // R2
        else $error("Decrement to zero did not set the flag.");
    a_irq_follows_flag: assert property (irq_o == (ctl.zero_flag && ctl.zero_irq_enable)) // R3
        else $error("Interrupt does not follow flag and enable.");
    a_write_loads_count: assert property (wr_cnt |=> count_register == $past(wbyte)) // R5
        else $error("Count write not loaded.");
    a_write_zero_flags: assert property (wr_cnt && wbyte == CNT_ZERO |=> ctl.zero_flag) // R6
        else $error("Writing zero count did not set the flag.");
    a_write_beats_decr: assert property (wr_cnt && cnt_hits_zero && wbyte != CNT_ZERO // R8
        && !wr_ctl && !ctl.zero_flag |=> !ctl.zero_flag)
        else $error("Flag set despite a winning count write.");
    a_stopped_holds: assert property (!ctl.prescale_run && !wr_cnt // R19
        |=> prescaler == PSC_RELOAD && $stable(count_register))
        else $error("Stopped timer moved.");
    a_count_reload: assert property (cnt_tick && !wr_cnt && count_register == CNT_ZERO // R17
        |=> count_register == CNT_RELOAD)
        else $error("Counter did not reload after zero.");
    a_psc_reload: assert property (psc_step && !wr_psc && prescaler == PSC_ZERO // R18
        |=> prescaler == PSC_RELOAD)
        else $error("Prescaler did not reload after zero.");
    a_gated_low_holds: assert property (mode == PDT_GATED && !pin_s2 && !wr_psc // R11
        && ctl.prescale_run |=> $stable(prescaler))
        else $error("Gated prescaler moved with the pin low.");
    a_pin_latches_data: assert property ($rose(ctl.zero_flag) |-> pin_o == $past(ctl.data_bit)) // R15
        else $error("Pin level is not the latched data bit.");
    a_pin_drive: assert property (pin_oe_o == (mode == PDT_OUTPUT)) // R16
        else $error("Pin enable does not follow direction.");
    a_ctl_write: assert property (wr_ctl |=> ctl[6:0] == $past(wbyte[6:0])) // R9
        else $error("Control write not loaded.");
    a_psc_write: assert property (wr_psc && ctl.prescale_run
        |=> prescaler == $past(wbyte[PSC_W-1:0]))
        else $error("Prescaler write not loaded while running.");

    ////////////////////////////////////////////////////////////////////////
    // Pin path checks. The pin is seen late on purpose, so edges are judged some clocks back.
    a_sync_delay: assert property (pin_rise |-> $past(pin_i, 2) && !$past(pin_i, 3)) // R21
        else $error("Pin edge not taken through the synchroniser.");
    a_event_step: assert property (mode == PDT_EVENT && ctl.prescale_run && !wr_psc && pin_rise // R13
        |=> $changed(prescaler))
        else $error("Event prescaler missed a pin edge.");
    a_event_idle: assert property (mode == PDT_EVENT && ctl.prescale_run && !wr_psc && !pin_rise // R13
        |=> $stable(prescaler))
        else $error("Event prescaler moved without a pin edge.");
    a_gated_high_steps: assert property (mode == PDT_GATED && ctl.prescale_run && !wr_psc // R11
        && pin_s2 |=> $changed(prescaler) == $past(div_tick))
        else $error("Gated prescaler ignored the divided tick.");
    a_output_divided: assert property (mode == PDT_OUTPUT && ctl.prescale_run && !wr_psc // R14
        |=> $changed(prescaler) == $past(div_tick))
        else $error("Output mode prescaler not on the divided tick.");
    a_latch_holds: assert property (!$rose(ctl.zero_flag) |-> $stable(pin_o)) // R15
        else $error("Pin level moved without a rising flag.");
    a_flag_holds: assert property (!cnt_hits_zero && !wr_cnt && !wr_ctl // R2
        |=> $stable(ctl.zero_flag))
        else $error("Zero flag changed with no cause.");
    a_flag_clear: assert property (wr_ctl && !wbyte[CTL_ZF_BIT] && !cnt_hits_zero && !wr_cnt // R7
        |=> !ctl.zero_flag)
        else $error("Zero flag not cleared by software.");

    ////////////////////////////////////////////////////////////////////////
    // Bus checks. A response must stand until the master takes it, or it is lost.
    a_write_answer: assert property (wr_go |=> s_axi_bvalid_o)
        else $error("Write taken without a response.");
    a_read_answer: assert property (rd_go |=> s_axi_rvalid_o)
        else $error("Read taken without a response.");
    a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response dropped before it was taken.");
    a_rdata_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("Read response dropped before it was taken.");
    a_unmapped_read: assert property (rd_go && !is_mapped(s_axi_araddr_i)
        |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("Unmapped read not refused.");

    // Cover points for the main scenarios.
    c_underflow: cover property (cnt_hits_zero ##1 ctl.zero_flag);
    c_event_count: cover property (mode == PDT_EVENT && psc_step);
    c_gated_count: cover property (mode == PDT_GATED && cnt_tick);
    c_output_toggle: cover property (pin_oe_o && $changed(pin_o));
    c_write_beats_decr: cover property (wr_cnt && cnt_hits_zero);

endmodule : pdt_timer

// ==== bench/pdt_pin_model.sv ====
// Purpose: Far-side model of the timer pin.
// Assumes: The pin line has a pull-up while nobody drives it.
// Notes: Pulses last three clocks, slow enough for the input synchroniser.
`timescale 1ns/1ps
module pdt_pin_model (
    // Clock.
    input wire logic clock_i,
    // Pin as seen from the timer.
    input wire logic pin_o,
    input wire logic pin_oe_o,
    output logic pin_i
);
    logic drive = 1'b0;
    logic level = 1'b1;
    // A released line rises to the pull-up; the timer output overrides all.
    assign pin_i = pin_oe_o ? pin_o : (drive ? level : 1'b1);
    ////////////////////////////////////////////////////////////////
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock_i);
            drive <= 1'b1;
            level <= 1'b0;
            repeat (3) @(posedge clock_i);
            level <= 1'b1;
            repeat (3) @(posedge clock_i);
        end
        repeat (6) @(posedge clock_i);
    endtask : pulses
    task automatic hold(input logic l);
        @(posedge clock_i);
        drive <= 1'b1;
        level <= l;
    endtask : hold
endmodule : pdt_pin_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the prescaled downcounter timer.
// Assumes: Divided tick shortened to 2 clocks to keep the run short.
// Notes: Bus results are checked against a queue of expected notes.
`timescale 1ns/1ps
module tb_top;
    import pdt_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin_i, pin_o, pin_oe, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] notes[$];
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] k;
    logic [3:0] wstrb = 4'hf;
    initial forever #5 clock_i = ~clock_i;
    pdt_timer #(.DIV(2)) i_dut (.clock_i(clock_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .irq_o(irq));
    pdt_pin_model i_pin (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_i(pin_i));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Write holds address and data until both readies are sampled; read holds its address until arready.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back({r, 32'h0});
        @(posedge clock_i);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock_i); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clock_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] r);
        notes.push_back({r, 24'h0, e});
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd
    task automatic wait_irq();
        repeat (300) if (irq !== 1'b1) @(posedge clock_i);
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////
    // The watcher pairs every bus answer with the oldest expected note.
    always @(posedge clock_i) begin
        if (bvalid === 1'b1 && bready === 1'b1) check({bresp, 32'h0}, notes.pop_front());
        if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, notes.pop_front());
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h081b82e5));
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(ADDR_PSC, 8'h7f, RESP_OKAY);
        rd(ADDR_CNT, 8'hff, RESP_OKAY);
        rd(ADDR_CTL, 8'h00, RESP_OKAY);
        rd(12'h000, 8'h00, RESP_SLVERR);
        wr(12'h004, 8'h5a, RESP_SLVERR);
        k = 8'($urandom_range(255, 1));
        wr(ADDR_CNT, k, RESP_OKAY);
        // A write without its low byte lane is answered but must change nothing.
        wstrb <= 4'h0;
        wr(ADDR_CNT, 8'h00, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_CTL, 8'h00, RESP_OKAY);
        repeat (20) @(posedge clock_i);
        rd(ADDR_CNT, k, RESP_OKAY);
        wr(ADDR_PSC, 8'h11, RESP_OKAY);
        rd(ADDR_PSC, 8'h7f, RESP_OKAY);
        wr(ADDR_CNT, 8'h00, RESP_OKAY);
        rd(ADDR_CTL, 8'h80, RESP_OKAY);
        check(irq, 34'h0);
        wr(ADDR_CTL, 8'hc0, RESP_OKAY);
        check(irq, 34'h1);
        wr(ADDR_CTL, 8'h40, RESP_OKAY);
        check(irq, 34'h0);
        wr(ADDR_CTL, 8'h80, RESP_OKAY);
        rd(ADDR_CTL, 8'h80, RESP_OKAY);
        // Output mode: the latched data bit appears only once the flag rises.
        wr(ADDR_CTL, 8'h00, RESP_OKAY);
        wr(ADDR_CNT, 8'h03, RESP_OKAY);
        wr(ADDR_CTL, 8'h78, RESP_OKAY);
        check(pin_oe, 34'h1);
        check(pin_o, 34'h0);
        wait_irq();
        check(pin_o, 34'h1);
        // Event mode with select 1: two pin edges per count step.
        k = 8'($urandom_range(8, 1));
        wr(ADDR_CTL, 8'h00, RESP_OKAY);
        wr(ADDR_CNT, k, RESP_OKAY);
        wr(ADDR_CTL, 8'h09, RESP_OKAY);
        i_pin.pulses(2 * int'(k));
        rd(ADDR_CNT, 8'h00, RESP_OKAY);
        rd(ADDR_CTL, 8'h89, RESP_OKAY);
        wr(ADDR_CTL, 8'h08, RESP_OKAY);
        wr(ADDR_CNT, 8'h01, RESP_OKAY);
        i_pin.pulses(2);
        rd(ADDR_CNT, 8'hff, RESP_OKAY);
        rd(ADDR_CTL, 8'h88, RESP_OKAY);
        // Gated mode holds while the pin is low, then counts.
        wr(ADDR_CTL, 8'h00, RESP_OKAY);
        wr(ADDR_CNT, 8'h02, RESP_OKAY);
        i_pin.hold(1'b0);
        wr(ADDR_CTL, 8'h58, RESP_OKAY);
        repeat (60) @(posedge clock_i);
        rd(ADDR_CNT, 8'h02, RESP_OKAY);
        i_pin.hold(1'b1);
        wait_irq();
        check(irq, 34'h1);
        repeat (4) @(posedge clock_i);
        wrap_up();
    end
endmodule : tb_top
